// >>> pic_clock.sv
/*
  Programmable interval clock: 12-bit counter, buffer, enable register,
  status flags, decade time base and the io transfer instruction port.
  Assumes a 20 MHz ref_clk, inputs synchronous to it, and a host that
  issues one instruction at a time and waits for its done pulse.
*/
// Function
// - 12-bit counter, overflow flag, 12-bit buffer
// - decade dividers give 1 MHz to 100 Hz
// - rate field picks stop, external or decade
// - enable bit 0 lets overflow interrupt
// - mode 00 free runs, flag stays set
// - mode 01 reloads counter from buffer on overflow
// - mode 10 enabled event copies counter to buffer
// - mode 11 event copies then restarts from zero
// - skip when any enabled condition holds
// - accumulator to buffer, buffer to counter
// - clear enable bits where accumulator is one
// - set enable bits where accumulator is one
// - return enable register to accumulator
// - or status in, clear reported bits
// - overflow bit 0, events at bits 9-11
// - enable bits 9-11 enable channels 3-1
// - clear accumulator, load buffer into it
// - capture counter to buffer, then to accumulator
// - counter read waits 300 ns after pulse
// - inhibit bit stops counting
// - overflow may emit converter start pulse
// - events may also interrupt and set overflow
`timescale 1ns/100ps
`default_nettype none
`include "pic_defines.svh"

module pic_clock
  import pic_pkg::*;
(
  // clock and system clear
  input wire logic ref_clk,
  input wire logic rst,
  // instruction port
  input wire logic instr_valid,
  input wire pic_instr_t instr,
  output var pic_answer_t answer,
  output logic busy,
  // outside world
  input wire logic ext_count_in,
  input wire logic [2:0] event_in,
  output logic irq,
  output logic adc_start
);

  // --------------------------------------------------------------
  // functions
  // --------------------------------------------------------------
  function automatic logic rate_pulse(input logic [2:0] rate,
                                      input logic [4:0] ticks,
                                      input logic ext);
    case (rate)
      `PIC_RATE_EXT: rate_pulse = ext;
      `PIC_RATE_1MHZ: rate_pulse = ticks[0];
      `PIC_RATE_100KHZ: rate_pulse = ticks[1];
      `PIC_RATE_10KHZ: rate_pulse = ticks[2];
      `PIC_RATE_1KHZ: rate_pulse = ticks[3];
      `PIC_RATE_100HZ: rate_pulse = ticks[4];
      default: rate_pulse = 1'b0;
    endcase
  endfunction
  function automatic logic skip_cond(input logic [`PIC_W-1:0] en,
                                     input logic [`PIC_W-1:0] st);
    return (|(en[`PIC_EN_EVT_HI:`PIC_EN_EVT_LO] &
              st[`PIC_ST_EVT_HI:`PIC_ST_EVT_LO])) |
           (en[`PIC_EN_OVF_IRQ] & st[`PIC_ST_OVF]);
  endfunction

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  logic [`PIC_W-1:0] en_q;
  logic [`PIC_W-1:0] buf_q;
  logic [`PIC_W-1:0] cnt_q;
  logic [`PIC_W-1:0] st_q;
  logic [4:0] pre_q;
  logic [3:0] dec_q [`PIC_DECADES];
  logic [2:0] settle_q;
  logic ext_prev_q;
  logic [2:0] ev_prev_q;
  pic_state_t state_q;

  // --------------------------------------------------------------
  // decoded controls
  // --------------------------------------------------------------
  logic accept;
  logic [1:0] mode;
  logic [4:0] ticks;
  logic cnt_pulse;
  logic wrap;
  logic [2:0] ev_rise;
  logic [2:0] ev_on;
  logic ev_any;
  logic settled;
  logic ca_fire;
  logic op_ab;
  logic [`PIC_W-1:0] st_set;
  logic [`PIC_W-1:0] st_clr;
  logic [`PIC_W-1:0] acc_or_st;

  assign accept = instr_valid & (state_q == PIC_IDLE);
  assign op_ab = accept & (instr.code == `PIC_OP_AB);
  assign mode = en_q[`PIC_EN_MODE_HI:`PIC_EN_MODE_LO];
  // prescaler tick, then a decade chain
  always_comb
  begin
    ticks[0] = (pre_q == 5'(`PIC_PRESCALE - 1));
    for (int i = 0; i < `PIC_DECADES; i++)
    begin
      ticks[i+1] = ticks[i] & (dec_q[i] == 4'(`PIC_DECADE - 1));
    end
  end
  // count pulse, gated by the inhibit bit
  assign cnt_pulse =
    rate_pulse(en_q[`PIC_EN_RATE_HI:`PIC_EN_RATE_LO], ticks,
               ext_count_in & ~ext_prev_q)
    & ~en_q[`PIC_EN_INHIBIT];
  // the msb falls exactly when all ones step to zero
  assign wrap = cnt_pulse & (cnt_q == `PIC_CNT_MAX);
  assign ev_rise = event_in & ~ev_prev_q;
  assign ev_on = ev_rise & en_q[`PIC_EN_EVT_HI:`PIC_EN_EVT_LO];
  assign ev_any = |ev_on;
  // settle window is counted from the last count pulse
  assign settled = (settle_q >= 3'(`PIC_SETTLE_CYC)) & ~cnt_pulse;
  assign ca_fire = (state_q == PIC_SETTLE) & settled;
  always_comb
  begin
    st_set = `PIC_ZERO_WORD;
    st_set[`PIC_ST_EVT_HI:`PIC_ST_EVT_LO] = ev_rise;
    st_set[`PIC_ST_OVF] = wrap |
      (en_q[`PIC_EN_EVT_OVF] & ev_any);
  end
  assign acc_or_st = instr.acc | st_q;
  assign st_clr = (accept & (instr.code == `PIC_OP_RD_ST)) ?
                  acc_or_st : `PIC_ZERO_WORD;

  // --------------------------------------------------------------
  // time base
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pre_q <= 5'h00;
    end
    else
    begin
      pre_q <= ticks[0] ? 5'h00 : pre_q + 5'h01;
    end
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dec_q <= '{default: 4'h0};
    end
    else
    begin
      for (int i = 0; i < `PIC_DECADES; i++)
      begin
        if (ticks[i+1])
        begin
          dec_q[i] <= 4'h0;
        end
        else if (ticks[i])
        begin
          dec_q[i] <= dec_q[i] + 4'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // input edge detection and read settling
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_prev_q <= 1'b0;
      ev_prev_q <= 3'h0;
    end
    else
    begin
      ext_prev_q <= ext_count_in;
      ev_prev_q <= event_in;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      settle_q <= 3'(`PIC_SETTLE_CYC);
    end
    else if (cnt_pulse)
    begin
      settle_q <= 3'h0;
    end
    else if (settle_q < 3'(`PIC_SETTLE_CYC))
    begin
      settle_q <= settle_q + 3'h1;
    end
  end

  // --------------------------------------------------------------
  // counter
  // --------------------------------------------------------------
  // a preset beats a restart, which beats a count on the same edge
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= `PIC_ZERO_WORD;
    end
    else if (op_ab)
    begin
      cnt_q <= instr.acc;
    end
    else if ((mode == `PIC_MODE_RESTART) && ev_any)
    begin
      cnt_q <= `PIC_ZERO_WORD;
    end
    else if (wrap)
    begin
      cnt_q <= (mode == `PIC_MODE_RELOAD) ? buf_q :
               `PIC_ZERO_WORD;
    end
    else if (cnt_pulse)
    begin
      cnt_q <= cnt_q + `PIC_CNT_ONE;
    end
  end

  // --------------------------------------------------------------
  // buffer
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      buf_q <= `PIC_ZERO_WORD;
    end
    else if (op_ab)
    begin
      buf_q <= instr.acc;
    end
    else if (ca_fire)
    begin
      buf_q <= cnt_q;
    end
    else if (ev_any && (mode == `PIC_MODE_CAPTURE ||
                        mode == `PIC_MODE_RESTART))
    begin
      buf_q <= cnt_q;
    end
  end

  // --------------------------------------------------------------
  // enable register
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      en_q <= `PIC_ZERO_WORD;
    end
    else if (accept && instr.code == `PIC_OP_CLR_EN)
    begin
      en_q <= en_q & ~instr.acc;
    end
    else if (accept && instr.code == `PIC_OP_SET_EN)
    begin
      en_q <= en_q | instr.acc;
    end
  end

  // --------------------------------------------------------------
  // status flags
  // --------------------------------------------------------------
  // a new event in the clearing cycle survives the read
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= `PIC_ZERO_WORD;
    end
    else
    begin
      st_q <= (st_q & ~st_clr) | st_set;
    end
  end

  // --------------------------------------------------------------
  // instruction sequencing
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= PIC_IDLE;
      busy <= 1'b0;
    end
    else
    begin
      case (state_q)
        PIC_IDLE:
        begin
          if (accept && instr.code == `PIC_OP_CA)
          begin
            state_q <= PIC_SETTLE;
            busy <= 1'b1;
          end
        end
        PIC_SETTLE:
        begin
          if (ca_fire)
          begin
            state_q <= PIC_IDLE;
            busy <= 1'b0;
          end
        end
        default:
        begin
          state_q <= PIC_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // answer to the host
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      answer <= '0;
    end
    else if (ca_fire)
    begin
      answer <= '{done: 1'b1, acc_write: 1'b1,
                  skip: 1'b0, acc: cnt_q};
    end
    else if (accept && instr.code != `PIC_OP_CA)
    begin
      answer.done <= 1'b1;
      answer.skip <= 1'b0;
      answer.acc_write <= 1'b1;
      answer.acc <= instr.acc;
      case (instr.code)
        `PIC_OP_SKIP:
        begin
          answer.acc_write <= 1'b0;
          answer.skip <= skip_cond(en_q, st_q);
        end
        `PIC_OP_RD_EN: answer.acc <= en_q;
        `PIC_OP_RD_ST: answer.acc <= acc_or_st;
        `PIC_OP_BA: answer.acc <= buf_q;
        default: answer.acc_write <= 1'b0;
      endcase
    end
    else
    begin
      answer.done <= 1'b0;
      answer.acc_write <= 1'b0;
      answer.skip <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // interrupt and converter start
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq <= 1'b0;
      adc_start <= 1'b0;
    end
    else
    begin
      irq <= skip_cond(en_q, st_q);
      adc_start <= wrap & en_q[`PIC_EN_ADC];
    end
  end

endmodule
`default_nettype wire

// >>> pic_defines.svh
/*
  Named constants for the programmable interval clock: enable and
  status field positions, instruction codes, rates, modes and timing.
  Assumes it is included by bare name from pic_pkg.sv and pic_clock.sv.
*/
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

`define PIC_W 12
`define PIC_ZERO_WORD 12'h000
`define PIC_CNT_MAX 12'hfff
`define PIC_CNT_ONE 12'h001

// enable register fields (documented bit n sits at index 11-n)
`define PIC_EN_OVF_IRQ 11
`define PIC_EN_MODE_HI 10
`define PIC_EN_MODE_LO 9
`define PIC_EN_RATE_HI 8
`define PIC_EN_RATE_LO 6
`define PIC_EN_ADC 5
`define PIC_EN_INHIBIT 4
`define PIC_EN_EVT_OVF 3
`define PIC_EN_EVT_HI 2
`define PIC_EN_EVT_LO 0

// status word fields, event index 0 is channel 1
`define PIC_ST_OVF 11
`define PIC_ST_EVT_HI 2
`define PIC_ST_EVT_LO 0

// low octal digit of the io transfer instruction
`define PIC_OP_CLR_EN 3'h0
`define PIC_OP_SKIP 3'h1
`define PIC_OP_SET_EN 3'h2
`define PIC_OP_AB 3'h3
`define PIC_OP_RD_EN 3'h4
`define PIC_OP_RD_ST 3'h5
`define PIC_OP_BA 3'h6
`define PIC_OP_CA 3'h7

// rate field codes
`define PIC_RATE_STOP_LO 3'h0
`define PIC_RATE_EXT 3'h1
`define PIC_RATE_100HZ 3'h2
`define PIC_RATE_1KHZ 3'h3
`define PIC_RATE_10KHZ 3'h4
`define PIC_RATE_100KHZ 3'h5
`define PIC_RATE_1MHZ 3'h6
`define PIC_RATE_STOP_HI 3'h7

// mode field codes
`define PIC_MODE_FREE 2'h0
`define PIC_MODE_RELOAD 2'h1
`define PIC_MODE_CAPTURE 2'h2
`define PIC_MODE_RESTART 2'h3

// time base and read settling
`define PIC_REF_HZ 20000000
`define PIC_TICK_HZ 1000000
`define PIC_PRESCALE (`PIC_REF_HZ / `PIC_TICK_HZ)
`define PIC_DECADE 10
`define PIC_DECADES 4
`define PIC_CLK_NS 50
`define PIC_SETTLE_NS 300
`define PIC_SETTLE_CYC ((`PIC_SETTLE_NS + `PIC_CLK_NS - 1) / `PIC_CLK_NS)

`endif

// >>> pic_pkg.sv
/*
  Types of the programmable interval clock: instruction request,
  instruction answer and the control state.
  Assumes pic_defines.svh is reachable on the include path.
*/
`include "pic_defines.svh"

package pic_pkg;

  typedef struct packed
  {
    logic [2:0] code;
    logic [`PIC_W-1:0] acc;
  } pic_instr_t;

  typedef struct packed
  {
    logic done;
    logic acc_write;
    logic skip;
    logic [`PIC_W-1:0] acc;
  } pic_answer_t;

  typedef enum logic [1:0]
  {
    PIC_IDLE = 2'b01,
    PIC_SETTLE = 2'b10
  } pic_state_t;

endpackage

// >>> pic_monitor.sv
/*
  Port checker for pic_clock.
  Assumes it is bound to pic_clock and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module pic_monitor
  import pic_pkg::*;
(
  // clock and system clear
  input wire logic ref_clk,
  input wire logic rst,
  // instruction port
  input wire logic instr_valid,
  input wire pic_instr_t instr,
  input wire pic_answer_t answer,
  input wire logic busy,
  // outside world
  input wire logic ext_count_in,
  input wire logic [2:0] event_in,
  input wire logic irq,
  input wire logic adc_start
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic take;
  assign take = instr_valid && !busy;

  chk_quick_done: assert property
    (take && instr.code != 3'h7 |=> answer.done)
    else $error("answer late");
  chk_acc_kept: assert property
    (take && instr.code < 3'h4 |=> !answer.acc_write)
    else $error("accumulator written");
  chk_acc_given: assert property
    (take && instr.code inside {[3'h4:3'h6]} |=> answer.acc_write)
    else $error("accumulator not written");
  chk_status_or: assert property
    (take && instr.code == 3'h5 |=>
     (answer.acc & $past(instr.acc)) == $past(instr.acc))
    else $error("status not ored");
  chk_skip_irq: assert property
    (take && instr.code == 3'h1 |=> answer.skip == irq)
    else $error("skip and irq differ");
  chk_skip_only: assert property
    (take && instr.code != 3'h1 |=> !answer.skip)
    else $error("stray skip");
  chk_capture_busy: assert property
    (take && instr.code == 3'h7 |=> busy)
    else $error("busy missing");
  // worst case: a 1 MHz pulse in the cycle after the request adds seven
  chk_settle_bound: assert property
    (take && instr.code == 3'h7 |-> ##[2:9] answer.done)
    else $error("capture too slow");
  chk_busy_end: assert property
    ($fell(busy) |-> answer.done && answer.acc_write)
    else $error("busy ended without answer");
  chk_adc_single: assert property
    (adc_start |=> !adc_start)
    else $error("start pulse too long");

  cover property (take && instr.code == 3'h7);
  cover property (adc_start);
  cover property (answer.skip);
endmodule

bind pic_clock pic_monitor mon (
  .ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
  .answer(answer), .busy(busy), .ext_count_in(ext_count_in),
  .event_in(event_in), .irq(irq), .adc_start(adc_start)
);

`default_nettype wire

// >>> pic_host_model.sv
/*
  Host processor model issuing io transfer instructions.
  Assumes one instruction at a time, answer within 12 cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module pic_host_model
  import pic_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // instruction port
  output logic instr_valid,
  output pic_instr_t instr,
  input wire pic_answer_t answer,
  input wire logic busy
);
  // ----------------------------------------
  // instruction issue
  // ----------------------------------------
  initial
  begin
    instr_valid = 1'b0;
    instr = '0;
  end

  // accumulator kept unless the answer replaces it
  task automatic exec(input logic [2:0] c, input logic [11:0] a,
                      output logic [11:0] acc_out, output logic skp,
                      output logic ok);
    int n;
    ok = 1'b0;
    acc_out = a;
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr <= '{code: c, acc: a};
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    // idle word inverted so a stale value is never mistaken
    instr.acc <= ~a;
    for (n = 0; n < 12 && !ok; n++)
    begin
      @(negedge ref_clk);
      ok = (answer.done === 1'b1);
    end
    if (ok && answer.acc_write === 1'b1)
      acc_out = answer.acc;
    skp = ok && (answer.skip === 1'b1);
  endtask
endmodule

`default_nettype wire

// >>> testbench.sv
/*
  Self-checking testbench for pic_clock.
  Assumes pic_monitor is bound and pic_host_model issues instructions.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ext_count_in = 1'b0;
  logic [2:0] event_in = 3'h0;
  logic instr_valid;
  logic busy;
  logic irq;
  logic adc_start;
  pic_pkg::pic_instr_t instr;
  pic_pkg::pic_answer_t answer;
  logic [11:0] acc_r;
  logic [11:0] adc_seen = 12'h000;
  logic skp_r;
  logic ok_r;
  int err_count = 0;
  int n_compared = 0;

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
    if (adc_start === 1'b1)
      adc_seen <= adc_seen + 12'h001;

  pic_clock DUT (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .answer(answer), .busy(busy), .ext_count_in(ext_count_in),
    .event_in(event_in), .irq(irq), .adc_start(adc_start));

  pic_host_model host (.ref_clk(ref_clk), .instr_valid(instr_valid),
    .instr(instr), .answer(answer), .busy(busy));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input string what, input logic [11:0] exp,
             input logic [11:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a missing answer counts as a mismatch and ends the run
  task op_get(input logic [2:0] c, input logic [11:0] a);
    host.exec(c, a, acc_r, skp_r, ok_r);
    if (!ok_r)
    begin
      err_count++;
      report_and_stop();
    end
  endtask

  task op(input logic [2:0] c, input logic [11:0] a, input logic [11:0] exp);
    op_get(c, a);
    check("accumulator", exp, acc_r);
  endtask

  task ext(input int n);
    repeat (n)
    begin
      @(posedge ref_clk) ext_count_in <= 1'b1;
      @(posedge ref_clk) ext_count_in <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
  endtask

  task evt(input int i);
    @(posedge ref_clk) event_in[i] <= 1'b1;
    @(posedge ref_clk) event_in[i] <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset_regs;
    op(3'h4, 12'h000, 12'h000);
    op(3'h6, 12'hfff, 12'h000);
    op(3'h5, 12'h000, 12'h000);
    $display("t_reset_regs done");
  endtask

  task t_enable_bits;
    op(3'h2, 12'ha5a, 12'ha5a);
    op(3'h0, 12'h00f, 12'h00f);
    op(3'h4, 12'h123, 12'ha50);
    op(3'h0, 12'hfff, 12'hfff);
    $display("t_enable_bits done");
  endtask

  task t_preset_stop;
    op(3'h3, 12'h123, 12'h123);
    op(3'h6, 12'h000, 12'h123);
    ext(2);
    op(3'h7, 12'hfff, 12'h123);
    op(3'h2, 12'h1c0, 12'h1c0);
    ext(2);
    op(3'h7, 12'h000, 12'h123);
    op(3'h0, 12'hfff, 12'hfff);
    $display("t_preset_stop done");
  endtask

  task t_wrap;
    op(3'h2, 12'h860, 12'h860);
    op(3'h3, 12'hffe, 12'hffe);
    ext(2);
    op(3'h7, 12'h000, 12'h000);
    check("adc pulses", 12'h001, adc_seen);
    op(3'h1, 12'h000, 12'h000);
    check("skip", 12'h001, {11'h0, skp_r});
    check("irq", 12'h001, {11'h0, irq});
    op(3'h5, 12'h000, 12'h800);
    op(3'h5, 12'h000, 12'h000);
    op(3'h0, 12'hfff, 12'hfff);
    $display("t_wrap done");
  endtask

  task t_reload;
    op(3'h2, 12'h240, 12'h240);
    op(3'h3, 12'hfff, 12'hfff);
    ext(1);
    op(3'h7, 12'h000, 12'hfff);
    op(3'h5, 12'h000, 12'h800);
    op(3'h2, 12'h010, 12'h010);
    ext(3);
    op(3'h7, 12'h000, 12'hfff);
    op(3'h0, 12'hfff, 12'hfff);
    $display("t_reload done");
  endtask

  task t_capture;
    op(3'h2, 12'h449, 12'h449);
    op(3'h3, 12'h010, 12'h010);
    ext(3);
    evt(0);
    ext(1);
    op(3'h6, 12'h000, 12'h013);
    op(3'h7, 12'h000, 12'h014);
    op(3'h1, 12'h000, 12'h000);
    check("skip", 12'h001, {11'h0, skp_r});
    op(3'h5, 12'h000, 12'h801);
    op(3'h0, 12'h008, 12'h008);
    ext(1);
    evt(2);
    op(3'h6, 12'h000, 12'h014);
    op(3'h5, 12'h000, 12'h004);
    op(3'h0, 12'hfff, 12'hfff);
    $display("t_capture done");
  endtask

  task t_restart;
    op(3'h2, 12'h642, 12'h642);
    op(3'h3, 12'h020, 12'h020);
    ext(1);
    evt(1);
    ext(2);
    op(3'h6, 12'h000, 12'h021);
    op(3'h7, 12'h000, 12'h002);
    op(3'h0, 12'hfff, 12'hfff);
    $display("t_restart done");
  endtask

  task t_fast_rate;
    logic in_rng;
    op(3'h3, 12'h000, 12'h000);
    op(3'h2, 12'h180, 12'h180);
    // 402 to 409 counting edges before the capture: 20 or 21 ticks
    repeat (400) @(posedge ref_clk);
    op_get(3'h7, 12'h000);
    in_rng = acc_r inside {[12'h014:12'h015]};
    check("ticks in range", 12'h001, {11'h0, in_rng});
    op(3'h0, 12'hfff, 12'hfff);
    $display("t_fast_rate done");
  endtask

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset_regs();
    t_enable_bits();
    t_preset_stop();
    t_wrap();
    t_reload();
    t_capture();
    t_restart();
    t_fast_rate();
    report_and_stop();
  end
endmodule

`default_nettype wire
